// File: hdl/cbiw_pkg.sv
// constants, types and helpers for the card bridge io window and irq config block
package cbiw_pkg;
   localparam int unsigned CBIW_NUM_WIN      = 2;
   localparam int unsigned CBIW_NUM_FUNC     = 2;
   localparam logic [7:0]  CBIW_OFS_BOTTOM0  = 8'h2c;
   localparam logic [7:0]  CBIW_OFS_TOP0     = 8'h30;
   localparam logic [7:0]  CBIW_OFS_BOTTOM1  = 8'h34;
   localparam logic [7:0]  CBIW_OFS_TOP1     = 8'h38;
   localparam logic [7:0]  CBIW_OFS_IRQ      = 8'h3c;
   localparam logic [7:0]  CBIW_OFS_IRQ_PIN  = 8'h3d;
   localparam logic [31:0] CBIW_BOTTOM_WMASK = 32'hffff_fffc;
   localparam logic [31:0] CBIW_TOP_WMASK    = 32'h0000_fffc;
   localparam logic [31:0] CBIW_WIN_RESET    = 32'h0000_0000;
   localparam logic [7:0]  CBIW_LINE_RESET   = 8'hff;
   localparam logic [7:0]  CBIW_PIN_INTA     = 8'h01;
   localparam logic [7:0]  CBIW_PIN_INTB     = 8'h02;
   localparam logic [0:0]  CBIW_FUNC_BRIDGE  = 1'h0;
   localparam logic [0:0]  CBIW_FUNC_SECOND  = 1'h1;
   localparam int unsigned CBIW_PAGE_LSB     = 16;
   localparam int unsigned CBIW_DW_LSB       = 2;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [0:0]  func;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cbiw_cfg_req_t;

   typedef struct packed {
      logic        req;
      logic [31:0] addr;
   } cbiw_io_req_t;

   // byte-lane write merge limited to writable bits
   function automatic logic [31:0] cbiw_merge(input logic [31:0] old_v,
                                               input logic [31:0] wdata,
                                               input logic [3:0]  be,
                                               input logic [31:0] wmask);
      logic [31:0] lane;
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
      return (old_v & ~lane) | (wdata & lane);
   endfunction
endpackage

// File: hdl/cbiw_window_match.sv
// address compare of one io window
`timescale 1ns/1ps
module cbiw_window_match (
   input  wire logic [31:0] bottom,
   input  wire logic [31:0] top,
   input  wire logic [31:0] addr,
   output logic             hit
);
   import cbiw_pkg::*;
   logic enabled;
   logic same_page;
   logic above_bottom;
   logic below_top;

   always_comb begin
      enabled      = (bottom != CBIW_WIN_RESET) || (top != CBIW_WIN_RESET);
      same_page    = addr[31:CBIW_PAGE_LSB] == bottom[31:CBIW_PAGE_LSB];
      above_bottom = addr[15:CBIW_DW_LSB] >= bottom[15:CBIW_DW_LSB];
      below_top    = addr[15:0] <= {top[15:CBIW_DW_LSB], 2'h3};
      hit          = enabled && same_page && above_bottom && below_top;
   end
endmodule // cbiw_window_match

// File: hdl/cbiw_regs.sv
// config registers for io windows and interrupt line/pin of the card bridge
`timescale 1ns/1ps
module cbiw_regs (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire cbiw_pkg::cbiw_cfg_req_t cfg_req,
   output logic                       cfg_ack,
   output logic [31:0]                cfg_rdata,
   input  wire logic                  interrupt_tie,
   input  wire logic                  bridge_irq_req,
   input  wire logic                  second_irq_req,
   output logic                       irq_a,
   output logic                       irq_b,
   input  wire cbiw_pkg::cbiw_io_req_t pci_io,
   output logic                       pci_io_done,
   output logic                       pci_io_claim,
   input  wire cbiw_pkg::cbiw_io_req_t card_io,
   output logic                       card_io_done,
   output logic                       card_io_claim
);
   import cbiw_pkg::*;

   logic [31:0] bottom_ff [CBIW_NUM_WIN];
   logic [31:0] top_ff    [CBIW_NUM_WIN];
   logic [31:0] nxt_bottom[CBIW_NUM_WIN];
   logic [31:0] nxt_top   [CBIW_NUM_WIN];
   logic [7:0]  line_ff   [CBIW_NUM_FUNC];
   logic [7:0]  nxt_line  [CBIW_NUM_FUNC];
   logic        ack_ff,   nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        irq_a_ff, nxt_irq_a;
   logic        irq_b_ff, nxt_irq_b;
   logic        pci_done_ff,  nxt_pci_done;
   logic        pci_claim_ff, nxt_pci_claim;
   logic        card_done_ff,  nxt_card_done;
   logic        card_claim_ff, nxt_card_claim;
   logic [CBIW_NUM_WIN-1:0] pci_hit;
   logic [CBIW_NUM_WIN-1:0] card_hit;
   logic [7:0]  reported_irq_output;
   logic        bridge_fn;

   // one compare per window per direction
   genvar g;
   generate
      for (g = 0; g < CBIW_NUM_WIN; g++) begin : g_win
         cbiw_window_match u_pci_match (
            .bottom (bottom_ff[g]),
            .top    (top_ff[g]),
            .addr   (pci_io.addr),
            .hit    (pci_hit[g])
         );
         cbiw_window_match u_card_match (
            .bottom (bottom_ff[g]),
            .top    (top_ff[g]),
            .addr   (card_io.addr),
            .hit    (card_hit[g])
         );
      end
   endgenerate

   // config register file
   always_comb begin
      bridge_fn = cfg_req.func == CBIW_FUNC_BRIDGE;
      if (interrupt_tie || bridge_fn) begin
         reported_irq_output = CBIW_PIN_INTA;
      end else begin
         reported_irq_output = CBIW_PIN_INTB;
      end
      for (int i = 0; i < CBIW_NUM_WIN; i++) begin
         nxt_bottom[i] = bottom_ff[i];
         nxt_top[i]    = top_ff[i];
      end
      for (int f = 0; f < CBIW_NUM_FUNC; f++) begin
         nxt_line[f] = line_ff[f];
      end
      nxt_ack   = cfg_req.rd || cfg_req.wr;
      nxt_rdata = rdata_ff;
      if (cfg_req.wr) begin
         if (bridge_fn) begin
            case (cfg_req.addr)
               CBIW_OFS_BOTTOM0: nxt_bottom[0] = cbiw_merge(bottom_ff[0], cfg_req.wdata,
                                     cfg_req.be, CBIW_BOTTOM_WMASK);
               CBIW_OFS_TOP0:    nxt_top[0] = cbiw_merge(top_ff[0], cfg_req.wdata,
                                     cfg_req.be, CBIW_TOP_WMASK);
               CBIW_OFS_BOTTOM1: nxt_bottom[1] = cbiw_merge(bottom_ff[1], cfg_req.wdata,
                                     cfg_req.be, CBIW_BOTTOM_WMASK);
               CBIW_OFS_TOP1:    nxt_top[1] = cbiw_merge(top_ff[1], cfg_req.wdata,
                                     cfg_req.be, CBIW_TOP_WMASK);
               default: ;
            endcase
         end
         if (cfg_req.addr == CBIW_OFS_IRQ && cfg_req.be[0]) begin
            nxt_line[cfg_req.func] = cfg_req.wdata[7:0];
         end
      end
      if (cfg_req.rd) begin
         nxt_rdata = 32'h0000_0000;
         case (cfg_req.addr)
            CBIW_OFS_BOTTOM0: nxt_rdata = bridge_fn ? bottom_ff[0] : 32'h0000_0000;
            CBIW_OFS_TOP0:    nxt_rdata = bridge_fn ? top_ff[0] : 32'h0000_0000;
            CBIW_OFS_BOTTOM1: nxt_rdata = bridge_fn ? bottom_ff[1] : 32'h0000_0000;
            CBIW_OFS_TOP1:    nxt_rdata = bridge_fn ? top_ff[1] : 32'h0000_0000;
            CBIW_OFS_IRQ:     nxt_rdata = {16'h0000, reported_irq_output, line_ff[cfg_req.func]};
            default:          nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < CBIW_NUM_WIN; i++) begin
            bottom_ff[i] <= CBIW_WIN_RESET;
            top_ff[i]    <= CBIW_WIN_RESET;
         end
         for (int f = 0; f < CBIW_NUM_FUNC; f++) begin
            line_ff[f] <= CBIW_LINE_RESET;
         end
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         bottom_ff <= nxt_bottom;
         top_ff    <= nxt_top;
         line_ff   <= nxt_line;
         ack_ff    <= nxt_ack;
         rdata_ff  <= nxt_rdata;
      end
   end

   // interrupt output routing
   always_comb begin
      nxt_irq_a = bridge_irq_req || (interrupt_tie && second_irq_req);
      nxt_irq_b = !interrupt_tie && second_irq_req;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_a_ff <= 1'b0;
         irq_b_ff <= 1'b0;
      end else begin
         irq_a_ff <= nxt_irq_a;
         irq_b_ff <= nxt_irq_b;
      end
   end

   // forwarding decisions in both directions
   always_comb begin
      nxt_pci_done   = pci_io.req;
      nxt_pci_claim  = pci_io.req && (|pci_hit);
      nxt_card_done  = card_io.req;
      nxt_card_claim = card_io.req && (|card_hit);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pci_done_ff   <= 1'b0;
         pci_claim_ff  <= 1'b0;
         card_done_ff  <= 1'b0;
         card_claim_ff <= 1'b0;
      end else begin
         pci_done_ff   <= nxt_pci_done;
         pci_claim_ff  <= nxt_pci_claim;
         card_done_ff  <= nxt_card_done;
         card_claim_ff <= nxt_card_claim;
      end
   end

   assign cfg_ack       = ack_ff;
   assign cfg_rdata     = rdata_ff;
   assign irq_a         = irq_a_ff;
   assign irq_b         = irq_b_ff;
   assign pci_io_done   = pci_done_ff;
   assign pci_io_claim  = pci_claim_ff;
   assign card_io_done  = card_done_ff;
   assign card_io_claim = card_claim_ff;

   a_bottom_low_zero: assert property (@(posedge ref_clk) disable iff (rst)
      bottom_ff[0][1:0] == 2'h0 && bottom_ff[1][1:0] == 2'h0)
      else $error("io bottom low bits not zero");
   a_top_high_zero: assert property (@(posedge ref_clk) disable iff (rst)
      top_ff[0][31:16] == 16'h0000 && top_ff[1][31:16] == 16'h0000
      && top_ff[0][1:0] == 2'h0 && top_ff[1][1:0] == 2'h0)
      else $error("io top read-only bits not zero");
   a_bottom_write_kept: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_req.wr && cfg_req.func == 1'h0 && cfg_req.addr == 8'h2c && cfg_req.be == 4'hf
      |=> bottom_ff[0] == ($past(cfg_req.wdata) & 32'hffff_fffc))
      else $error("io bottom write not stored");
   a_line_reset_ones: assert property (@(posedge ref_clk)
      rst |=> line_ff[0] == 8'hff && line_ff[1] == 8'hff)
      else $error("irq line not all ones after reset");
   a_pin_tied_one: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_req.rd && cfg_req.addr == 8'h3c && interrupt_tie
      |=> cfg_ack && cfg_rdata[15:8] == 8'h01)
      else $error("irq pin wrong with tie set");
   a_pin_second_b: assert property (@(posedge ref_clk) disable iff (rst)
      cfg_req.rd && cfg_req.addr == 8'h3c && !interrupt_tie && cfg_req.func == 1'h1
      |=> cfg_rdata[15:8] == 8'h02)
      else $error("irq pin of second function not 02h");
   a_irq_tie_merge: assert property (@(posedge ref_clk) disable iff (rst)
      interrupt_tie && second_irq_req |=> irq_a && !irq_b)
      else $error("tied interrupt not merged onto first output");
   a_window_off_idle: assert property (@(posedge ref_clk) disable iff (rst)
      pci_io.req && bottom_ff[0] == 32'h0 && top_ff[0] == 32'h0
      && bottom_ff[1] == 32'h0 && top_ff[1] == 32'h0 |=> pci_io_done && !pci_io_claim)
      else $error("disabled windows claimed an io cycle");
   a_top_word_incl: assert property (@(posedge ref_clk) disable iff (rst)
      card_io.req && card_io.addr[31:16] == bottom_ff[0][31:16]
      && card_io.addr[15:2] == top_ff[0][15:2] && card_io.addr[1:0] == 2'h3
      && bottom_ff[0][15:2] <= top_ff[0][15:2]
      && (bottom_ff[0] != 32'h0 || top_ff[0] != 32'h0) |=> card_io_claim)
      else $error("last byte of top word not claimed");
endmodule // cbiw_regs

// File: sim/cbiw_host_model.sv
// host side model: config cycles, io lookups and the tie setting
`timescale 1ns/1ps
module cbiw_host_model (
   input  wire logic              ref_clk,
   output cbiw_pkg::cbiw_cfg_req_t cfg_req,
   input  wire logic              cfg_ack,
   input  wire logic [31:0]       cfg_rdata,
   output cbiw_pkg::cbiw_io_req_t pci_io,
   input  wire logic              pci_io_done,
   input  wire logic              pci_io_claim,
   output cbiw_pkg::cbiw_io_req_t card_io,
   input  wire logic              card_io_done,
   input  wire logic              card_io_claim,
   output logic                   interrupt_tie
);
   import cbiw_pkg::*;
   logic serial_irq_signalling;
   initial begin
      cfg_req = '0;
      pci_io = '0;
      card_io = '0;
      interrupt_tie = 1'b0;
      serial_irq_signalling = 1'b0;
   end
   task automatic cfg(input logic wr, input logic [0:0] fn, input logic [7:0] ofs,
                      input logic [3:0] be, input logic [31:0] wd, output logic [32:0] res);
      @(posedge ref_clk);
      #1;
      cfg_req <= '{rd: !wr, wr: wr, func: fn, addr: ofs, be: be, wdata: wd};
      @(posedge ref_clk);
      #1;
      // released lines drop rd and wr and show the inverse on func, addr, be and wdata, never the stale value
      cfg_req <= '{rd: 1'b0, wr: 1'b0, func: ~fn, addr: ~ofs, be: ~be, wdata: ~wd};
      res = {cfg_ack, cfg_rdata};
   endtask
   task automatic look(input logic card, input logic [31:0] a, output logic [1:0] res);
      @(posedge ref_clk);
      #1;
      if (card) card_io <= '{req: 1'b1, addr: a};
      else pci_io <= '{req: 1'b1, addr: a};
      @(posedge ref_clk);
      #1;
      pci_io <= '{req: 1'b0, addr: ~a};
      card_io <= '{req: 1'b0, addr: ~a};
      res = card ? {card_io_done, card_io_claim} : {pci_io_done, pci_io_claim};
   endtask
   task automatic tie(input logic v);
      if (v) serial_irq_signalling = 1'b1;
      interrupt_tie <= v && serial_irq_signalling;
   endtask
endmodule // cbiw_host_model

// File: sim/cbiw_regs_bench.sv
// self-checking bench of the io window and irq config registers
`timescale 1ns/1ps
module cbiw_regs_bench;
   import cbiw_pkg::*;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          bridge_irq_req = 1'b0;
   logic          second_irq_req = 1'b0;
   cbiw_cfg_req_t cfg_req;
   cbiw_io_req_t  pci_io, card_io;
   logic          cfg_ack, interrupt_tie, irq_a, irq_b;
   logic          pci_io_done, pci_io_claim, card_io_done, card_io_claim;
   logic [31:0]   cfg_rdata;
   int            errors = 0;
   int            check_count = 0;
   logic [31:0]   hit_addr [6] = '{32'h1234_0100, 32'h1234_00fc, 32'h1234_0203,
                                   32'h1234_0204, 32'h1235_0100, 32'h0000_0000};
   logic          hit_exp [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   always #5 ref_clk = ~ref_clk;
   cbiw_regs dut (.ref_clk(ref_clk), .rst(rst), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
      .cfg_rdata(cfg_rdata), .interrupt_tie(interrupt_tie), .bridge_irq_req(bridge_irq_req),
      .second_irq_req(second_irq_req), .irq_a(irq_a), .irq_b(irq_b), .pci_io(pci_io),
      .pci_io_done(pci_io_done), .pci_io_claim(pci_io_claim), .card_io(card_io),
      .card_io_done(card_io_done), .card_io_claim(card_io_claim));
   cbiw_host_model host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
      .cfg_rdata(cfg_rdata), .pci_io(pci_io), .pci_io_done(pci_io_done),
      .pci_io_claim(pci_io_claim), .card_io(card_io), .card_io_done(card_io_done),
      .card_io_claim(card_io_claim), .interrupt_tie(interrupt_tie));
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {31'h0, exp}, {31'h0, got});
   endtask
   task automatic rd(input logic [0:0] fn, input logic [7:0] ofs, input logic [31:0] exp);
      logic [32:0] r;
      host.cfg(1'b0, fn, ofs, 4'h0, 32'h0, r);
      chk_bit("cfg_ack", 1'b1, r[32]);
      chk_word("cfg_rdata", exp, r[31:0]);
   endtask
   task automatic wr(input logic [0:0] fn, input logic [7:0] ofs, input logic [31:0] wd);
      logic [32:0] r;
      host.cfg(1'b1, fn, ofs, 4'hf, wd, r);
      chk_bit("cfg_ack", 1'b1, r[32]);
   endtask
   task automatic look(input logic [31:0] a, input logic exp);
      logic [1:0] r;
      for (int c = 0; c < 2; c++) begin
         host.look(c[0], a, r);
         chk_bit("io_done", 1'b1, r[1]);
         chk_bit("io_claim", exp, r[0]);
      end
   endtask
   task automatic irq_step(input logic b, input logic s, input logic ea, input logic eb);
      bridge_irq_req = b;
      second_irq_req = s;
      repeat (2) @(posedge ref_clk);
      #1;
      chk_bit("irq_a", ea, irq_a);
      chk_bit("irq_b", eb, irq_b);
   endtask
   task automatic stop_test;
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #20us;
      errors++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      look(32'h0000_0000, 1'b0);
      for (int i = 0; i < 4; i++) rd(1'b0, 8'h2c + 8'(4 * i), 32'h0);
      rd(1'b0, CBIW_OFS_IRQ, 32'h0000_01ff);
      rd(1'b1, CBIW_OFS_IRQ, 32'h0000_02ff);
      for (int i = 0; i < 4; i++) begin
         wr(1'b0, 8'h2c + 8'(4 * i), 32'hffff_ffff);
         rd(1'b0, 8'h2c + 8'(4 * i), i[0] ? 32'h0000_fffc : 32'hffff_fffc);
      end
      look(32'hffff_ffff, 1'b1);
      wr(1'b0, CBIW_OFS_BOTTOM0, 32'h1234_0100);
      wr(1'b0, CBIW_OFS_TOP0, 32'hffff_0200);
      rd(1'b0, CBIW_OFS_TOP0, 32'h0000_0200);
      wr(1'b0, CBIW_OFS_BOTTOM1, 32'h0);
      wr(1'b0, CBIW_OFS_TOP1, 32'h0);
      wr(1'b1, CBIW_OFS_BOTTOM0, 32'h0);
      rd(1'b0, CBIW_OFS_BOTTOM0, 32'h1234_0100);
      rd(1'b1, CBIW_OFS_BOTTOM0, 32'h0);
      foreach (hit_addr[i]) look(hit_addr[i], hit_exp[i]);
      irq_step(1'b1, 1'b0, 1'b1, 1'b0);
      irq_step(1'b0, 1'b1, 1'b0, 1'b1);
      host.tie(1'b1);
      irq_step(1'b0, 1'b1, 1'b1, 1'b0);
      rd(1'b1, CBIW_OFS_IRQ, 32'h0000_01ff);
      wr(1'b0, CBIW_OFS_IRQ, 32'hffff_ffa5);
      rd(1'b0, CBIW_OFS_IRQ, 32'h0000_01a5);
      rd(1'b1, CBIW_OFS_IRQ, 32'h0000_01ff);
      stop_test();
   end
endmodule // cbiw_regs_bench
